// ### include/ticap_defines.svh
// Constants of the timer input capture block: register indices,
// field positions, reset values and timing counts.
// Assumes a 32-bit classic Wishbone bus, one register per word.
`ifndef TICAP_DEFINES_SVH
`define TICAP_DEFINES_SVH

// Register indices; byte address is four times the index
`define TICAP_IDX_CAP1_HI 6'h10
`define TICAP_IDX_CAP1_LO 6'h11
`define TICAP_IDX_CAP2_HI 6'h12
`define TICAP_IDX_CAP2_LO 6'h13
`define TICAP_IDX_CAP3_HI 6'h14
`define TICAP_IDX_CAP3_LO 6'h15
`define TICAP_IDX_EDGE 6'h16
`define TICAP_IDX_PINCFG 6'h17
`define TICAP_IDX_STATUS 6'h18
`define TICAP_IDX_MASK 6'h19
`define TICAP_IDX_PINLVL 6'h1a

// Field positions
`define TICAP_EDGE_RISE_BIT 0
`define TICAP_EDGE_FALL_BIT 1
`define TICAP_EDGE_W 2
`define TICAP_PINCFG_CAPEN_LSB 0
`define TICAP_PINCFG_DIR_LSB 4
`define TICAP_PINCFG_GPO_LSB 8
`define TICAP_HI_MSB 15
`define TICAP_HI_LSB 8
`define TICAP_LO_MSB 7
`define TICAP_LO_LSB 0

// Reset values
`define TICAP_EDGE_RST 6'h00
`define TICAP_CAPEN_RST 3'h0
`define TICAP_DIR_RST 3'h0
`define TICAP_GPO_RST 3'h0
`define TICAP_STATUS_RST 3'h0
`define TICAP_MASK_RST 3'h0

// Cycles from a bus request to its acknowledge
`define TICAP_ACK_CYCLES 1

`endif

// ### include/ticap_pkg.sv
// Types of the timer input capture block.
// Assumes the defines header supplies all numeric constants.
package ticap_pkg;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } ticap_wb_req_s;

    typedef enum logic [1:0] {
        TICAP_EDGE_OFF,
        TICAP_EDGE_RISE,
        TICAP_EDGE_FALL,
        TICAP_EDGE_BOTH
    } ticap_edge_e;

    typedef logic [15:0] ticap_count_t;

endpackage : ticap_pkg

// ### core/ticap_top.sv
// Timer input capture: three capture channels, pin group control,
// event status with interrupt, and output compare pin timing.
// Assumes an outside free-running counter that pulses cnt_tick in the
// cycle in which it increments, and a classic Wishbone master.
//
// Summary of operation
// - Selected pin edge latches counter into channel
// - Captures commit only outside counter increment cycles
// - Compare pin change shows same fixed delay
// - Capture byte pairs mapped high then low
// - High byte bits 15:8; reset keeps captures
// - Pins serve capture inputs or general I/O
`timescale 1ns/1ps
`include "ticap_defines.svh"

module ticap_top (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    input wire ticap_pkg::ticap_wb_req_s wb_req,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire ticap_pkg::ticap_count_t tcnt,
    input wire logic cnt_tick,
    input wire logic oc_match,
    input wire logic oc_level,
    output logic oc_pin_q,
    input wire logic [2:0] pin_i,
    output logic [2:0] pin_o_q,
    output logic [2:0] pin_oe_n_q,
    output logic irq_q
);

    logic ack_q;
    logic [31:0] dat_q;
    logic [15:0] cap_q [3];
    logic [2:0] pin_prev_q;
    logic [2:0] pend_q;
    logic [2:0] pend_d;
    logic [2:0] sts_q;
    logic [2:0] sts_d;
    logic [2:0] msk_q;
    logic [2:0] capen_q;
    logic [2:0] dir_q;
    logic [2:0] gpo_q;
    logic [5:0] edge_q;
    logic oc_pend_q;
    logic oc_lvl_q;

    // Bus decode
    wire req_w = wb_req.cyc & wb_req.stb & ~ack_q;
    wire wr_w = req_w & wb_req.we;
    wire rd_w = req_w & ~wb_req.we;
    wire [5:0] idx_w = wb_req.adr[7:2];
    wire lane0_w = wb_req.sel[0];
    wire lane1_w = wb_req.sel[1];
    wire wr_edge_w = wr_w & lane0_w & (idx_w == `TICAP_IDX_EDGE);
    wire wr_cfg_w = wr_w & (idx_w == `TICAP_IDX_PINCFG);
    wire wr_sts_w = wr_w & lane0_w & (idx_w == `TICAP_IDX_STATUS);
    wire wr_msk_w = wr_w & lane0_w & (idx_w == `TICAP_IDX_MASK);
    wire [2:0] sts_clr_w = wr_sts_w ? wb_req.dat[2:0] : 3'h0;

    // Edge detection and capture commit
    wire [2:0] rise_w = pin_i & ~pin_prev_q;
    wire [2:0] fall_w = ~pin_i & pin_prev_q;
    wire commit_ok_w = ~cnt_tick;
    wire [2:0] commit_w = pend_q & {3{commit_ok_w}};
    logic [2:0] hit_w;

    genvar ch;
    generate
        for (ch = 0; ch < 3; ch++) begin : g_ch
            wire rise_en_w = edge_q[ch*`TICAP_EDGE_W+`TICAP_EDGE_RISE_BIT];
            wire fall_en_w = edge_q[ch*`TICAP_EDGE_W+`TICAP_EDGE_FALL_BIT];
            // Edge select and pin function gate the trigger
            assign hit_w[ch] = capen_q[ch] &
                ((rise_en_w & rise_w[ch]) | (fall_en_w & fall_w[ch]));

            // Capture register has no reset
            always_ff @(posedge mclk) begin
                if (ce && nrst && commit_w[ch]) begin
                    cap_q[ch] <= tcnt;
                end
            end
        end
    endgenerate

    // A new edge in the commit cycle stays pending
    assign pend_d = (pend_q & ~commit_w) | hit_w;
    // Set wins over software clear
    assign sts_d = (sts_q & ~sts_clr_w) | commit_w;

    // Read data selection
    wire [7:0] byte_w =
        (idx_w == `TICAP_IDX_CAP1_HI) ?
            cap_q[0][`TICAP_HI_MSB:`TICAP_HI_LSB] :
        (idx_w == `TICAP_IDX_CAP1_LO) ?
            cap_q[0][`TICAP_LO_MSB:`TICAP_LO_LSB] :
        (idx_w == `TICAP_IDX_CAP2_HI) ?
            cap_q[1][`TICAP_HI_MSB:`TICAP_HI_LSB] :
        (idx_w == `TICAP_IDX_CAP2_LO) ?
            cap_q[1][`TICAP_LO_MSB:`TICAP_LO_LSB] :
        (idx_w == `TICAP_IDX_CAP3_HI) ?
            cap_q[2][`TICAP_HI_MSB:`TICAP_HI_LSB] :
        (idx_w == `TICAP_IDX_CAP3_LO) ?
            cap_q[2][`TICAP_LO_MSB:`TICAP_LO_LSB] :
        (idx_w == `TICAP_IDX_EDGE) ? {2'h0, edge_q} :
        (idx_w == `TICAP_IDX_STATUS) ? {5'h00, sts_q} :
        (idx_w == `TICAP_IDX_MASK) ? {5'h00, msk_q} :
        (idx_w == `TICAP_IDX_PINLVL) ? {5'h00, pin_i} :
        8'h00;
    wire [15:0] cfg_w = {5'h00, gpo_q, 1'b0, dir_q, 1'b0, capen_q};
    wire [31:0] rdata_w = (idx_w == `TICAP_IDX_PINCFG) ?
        {16'h0000, cfg_w} : {24'h00_0000, byte_w};

    // Bus acknowledge and read data
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else if (ce) begin
            ack_q <= req_w;
            dat_q <= rd_w ? rdata_w : 32'h0000_0000;
        end
    end

    // Control registers
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            edge_q <= `TICAP_EDGE_RST;
            msk_q <= `TICAP_MASK_RST;
        end else if (ce) begin
            if (wr_edge_w) begin
                edge_q <= wb_req.dat[5:0];
            end
            if (wr_msk_w) begin
                msk_q <= wb_req.dat[2:0];
            end
        end
    end

    // Pin configuration
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            capen_q <= `TICAP_CAPEN_RST;
            dir_q <= `TICAP_DIR_RST;
            gpo_q <= `TICAP_GPO_RST;
        end else if (ce && wr_cfg_w) begin
            if (lane0_w) begin
                capen_q <= wb_req.dat[`TICAP_PINCFG_CAPEN_LSB +: 3];
                dir_q <= wb_req.dat[`TICAP_PINCFG_DIR_LSB +: 3];
            end
            if (lane1_w) begin
                gpo_q <= wb_req.dat[`TICAP_PINCFG_GPO_LSB +: 3];
            end
        end
    end

    // Previous pin level, a plain data history
    always_ff @(posedge mclk) begin
        if (ce) begin
            pin_prev_q <= pin_i;
        end
    end

    // Pending capture, status and interrupt
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pend_q <= 3'h0;
            sts_q <= `TICAP_STATUS_RST;
            irq_q <= 1'b0;
        end else if (ce) begin
            pend_q <= pend_d;
            sts_q <= sts_d;
            irq_q <= |(sts_d & msk_q);
        end
    end

    // Pin drivers: a capture pin is never driven
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pin_o_q <= 3'h0;
            pin_oe_n_q <= 3'h7;
        end else if (ce) begin
            pin_o_q <= gpo_q;
            pin_oe_n_q <= ~(dir_q & ~capen_q);
        end
    end

    // Compare output, same whole-cycle pending-stage timing as capture
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            oc_pend_q <= 1'b0;
            oc_lvl_q <= 1'b0;
            oc_pin_q <= 1'b0;
        end else if (ce) begin
            if (oc_match) begin
                oc_pend_q <= 1'b1;
                oc_lvl_q <= oc_level;
            end else if (oc_pend_q && commit_ok_w) begin
                oc_pend_q <= 1'b0;
            end
            if (oc_pend_q && commit_ok_w) begin
                oc_pin_q <= oc_lvl_q;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    generate
        for (ch = 0; ch < 3; ch++) begin : g_chk
            property p_cap_value;
                ce && pend_q[ch] && !cnt_tick |=> cap_q[ch] == $past(tcnt);
            endproperty
            a_cap_value: assert property (p_cap_value)
                else $error("capture did not take counter value");

            property p_edge_to_cap;
                ce && hit_w[ch] ##1 (ce && !cnt_tick)
                    |=> cap_q[ch] == $past(tcnt);
            endproperty
            a_edge_to_cap: assert property (p_edge_to_cap)
                else $error("edge did not capture one cycle later");

            property p_hold_on_tick;
                ce && cnt_tick |=> $stable(cap_q[ch]) &&
                    (pend_q[ch] || !$past(pend_q[ch]));
            endproperty
            a_hold_on_tick: assert property (p_hold_on_tick)
                else $error("capture taken while counter increments");

            property p_edge_off;
                ce && !pend_q[ch] && capen_q[ch] &&
                    edge_q[ch*2 +: 2] == 2'h0 |=> !pend_q[ch];
            endproperty
            a_edge_off: assert property (p_edge_off)
                else $error("disabled channel raised a capture");

            property p_cap_pin_input;
                ce && capen_q[ch] |=> pin_oe_n_q[ch];
            endproperty
            a_cap_pin_input: assert property (p_cap_pin_input)
                else $error("capture pin is being driven");

            property p_pend_on_hit;
                ce && hit_w[ch] |=> pend_q[ch];
            endproperty
            a_pend_on_hit: assert property (p_pend_on_hit)
                else $error("selected edge did not raise a capture");

            property p_commit_sets;
                ce && pend_q[ch] && !cnt_tick |=> sts_q[ch];
            endproperty
            a_commit_sets: assert property (p_commit_sets)
                else $error("capture did not set its status bit");

            property p_pin_drive;
                ce && dir_q[ch] && !capen_q[ch]
                    |=> !pin_oe_n_q[ch] && pin_o_q[ch] == $past(gpo_q[ch]);
            endproperty
            a_pin_drive: assert property (p_pin_drive)
                else $error("general output pin not driven");
        end
    endgenerate

    property p_oc_delay;
        ce && oc_pend_q && !oc_match && !cnt_tick
            |=> oc_pin_q == $past(oc_lvl_q) && !oc_pend_q;
    endproperty
    a_oc_delay: assert property (p_oc_delay)
        else $error("compare pin did not follow after delay");

    property p_oc_hold_on_tick;
        ce && oc_pend_q && cnt_tick |=> $stable(oc_pin_q);
    endproperty
    a_oc_hold_on_tick: assert property (p_oc_hold_on_tick)
        else $error("compare pin changed while counter increments");

    property p_read_hi;
        ce && rd_w && idx_w == `TICAP_IDX_CAP2_HI
            |=> ack_q && dat_q == {24'h00_0000, $past(cap_q[1][15:8])};
    endproperty
    a_read_hi: assert property (p_read_hi)
        else $error("high byte read returned wrong data");

    property p_read_lo;
        ce && rd_w && idx_w == `TICAP_IDX_CAP3_LO
            |=> ack_q && dat_q == {24'h00_0000, $past(cap_q[2][7:0])};
    endproperty
    a_read_lo: assert property (p_read_lo)
        else $error("low byte read returned wrong data");

    property p_reset_keeps;
        @(posedge mclk) disable iff (1'b0)
            !nrst && $past(nrst) && ce
                |=> $stable(cap_q[0]) && $stable(cap_q[2]);
    endproperty
    a_reset_keeps: assert property (p_reset_keeps)
        else $error("reset altered a capture register");

endmodule : ticap_top

// ### dv/ticap_pin_model.sv
// Far-side model: outside levels on the three capture pins.
// Assumes tgl is driven just after a rising edge of mclk.
`timescale 1ns/1ps
module ticap_pin_model (
    input wire logic mclk,
    input wire logic [2:0] tgl,
    input wire logic [2:0] oe_n,
    input wire logic [2:0] dout,
    output logic [2:0] pin
);
    logic [2:0] lvl_q = 3'h0;
    always @(posedge mclk) begin
        lvl_q <= lvl_q ^ tgl;
    end
    // Driven pins show the design's level, others the outside level
    assign pin = (~oe_n & dout) | (oe_n & lvl_q);
endmodule : ticap_pin_model

// ### dv/testbench.sv
// Self-checking bench: Wishbone tasks and capture scenarios.
// Assumes the outside counter and its tick are driven from here.
`timescale 1ns/1ps
`include "ticap_defines.svh"
module testbench;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    ticap_pkg::ticap_wb_req_s req = '0;
    ticap_pkg::ticap_count_t tcnt = 16'h0000;
    logic tick = 1'b0;
    logic oc_match = 1'b0;
    logic oc_level = 1'b0;
    logic [2:0] tgl = 3'h0;
    logic [2:0] pin;
    logic [2:0] pin_o;
    logic [2:0] oe_n;
    logic ack;
    logic oc_pin;
    logic irq;
    logic [31:0] dat;
    logic [31:0] q;
    logic [15:0] prev [3];
    logic [1:0] m;
    int n_errors = 0;
    int total_checks = 0;

    always #5 mclk = ~mclk;

    ticap_top dut (.mclk(mclk), .nrst(nrst), .ce(1'b1), .wb_req(req),
        .wb_ack_o(ack), .wb_dat_o(dat), .tcnt(tcnt), .cnt_tick(tick),
        .oc_match(oc_match), .oc_level(oc_level), .oc_pin_q(oc_pin),
        .pin_i(pin), .pin_o_q(pin_o), .pin_oe_n_q(oe_n), .irq_q(irq));
    ticap_pin_model far (.mclk(mclk), .tgl(tgl), .oe_n(oe_n),
        .dout(pin_o), .pin(pin));

    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk);
    endtask : wait_clk
    task automatic bus(input logic we, input logic [5:0] idx,
        input logic [31:0] d);
        @(posedge mclk);
        req <= '{1'b1, 1'b1, we, {idx, 2'b00}, 4'hf, d};
        do @(posedge mclk); while (ack !== 1'b1);
        q = dat;
        req <= '0;
    endtask : bus
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0000_0000);
        chk(q, exp);
    endtask : rd
    task automatic cap(input int ch, input logic [15:0] v);
        rd(`TICAP_IDX_CAP1_HI + 6'(2 * ch), 32'(v[15:8]));
        rd(`TICAP_IDX_CAP1_LO + 6'(2 * ch), 32'(v[7:0]));
    endtask : cap
    task automatic tog(input logic [2:0] msk);
        @(posedge mclk);
        tgl <= msk;
        @(posedge mclk);
        tgl <= 3'h0;
        wait_clk(4);
    endtask : tog
    task automatic step(input logic hit, input logic [15:0] v);
        tcnt <= v;
        tog(3'h7);
        for (int ch = 0; ch < 3; ch++) begin
            if (hit) prev[ch] = v;
            cap(ch, prev[ch]);
        end
    endtask : step
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    initial begin
        #200000;
        n_errors++;
        conclude();
    end

    initial begin
        wait_clk(5);
        nrst <= 1'b1;
        rd(`TICAP_IDX_STATUS, 32'h0000_0000);
        rd(6'h3f, 32'h0000_0000);
        chk(32'(oe_n), 32'h0000_0007);
        $display("test reset done");
        bus(1'b1, `TICAP_IDX_PINCFG, 32'h0000_0007);
        for (int i = 0; i < 4; i++) begin
            m = 2'((i + 3) % 4);
            bus(1'b1, `TICAP_IDX_EDGE, 32'({3{m}}));
            step(m[0], 16'ha5c0 + 16'(i));
            step(m[1], 16'h3c50 + 16'(i));
        end
        $display("test edge modes done");
        bus(1'b1, `TICAP_IDX_EDGE, 32'h0000_003f);
        tick <= 1'b1;
        tcnt <= 16'h1234;
        tog(3'h1);
        cap(0, prev[0]);
        tcnt <= 16'h5678;
        tick <= 1'b0;
        wait_clk(3);
        cap(0, 16'h5678);
        $display("test sync done");
        bus(1'b1, `TICAP_IDX_STATUS, 32'h0000_0007);
        rd(`TICAP_IDX_STATUS, 32'h0000_0000);
        tog(3'h2);
        rd(`TICAP_IDX_STATUS, 32'h0000_0002);
        chk(32'(irq), 32'h0000_0000);
        bus(1'b1, `TICAP_IDX_MASK, 32'h0000_0002);
        wait_clk(2);
        chk(32'(irq), 32'h0000_0001);
        bus(1'b1, `TICAP_IDX_STATUS, 32'h0000_0002);
        wait_clk(2);
        chk(32'(irq), 32'h0000_0000);
        $display("test interrupt done");
        nrst <= 1'b0;
        wait_clk(2);
        nrst <= 1'b1;
        cap(0, 16'h5678);
        cap(1, 16'h5678);
        $display("test reset keeps done");
        bus(1'b1, `TICAP_IDX_PINCFG, 32'h0000_0450);
        wait_clk(1);
        chk(32'({oe_n, pin_o}), 32'h0000_0014);
        bus(1'b0, `TICAP_IDX_PINLVL, 32'h0000_0000);
        chk(q & 32'h0000_0005, 32'h0000_0004);
        tog(3'h2);
        cap(1, 16'h5678);
        $display("test pin group done");
        oc_level <= 1'b1;
        tick <= 1'b1;
        oc_match <= 1'b1;
        wait_clk(1);
        oc_match <= 1'b0;
        wait_clk(3);
        chk(32'(oc_pin), 32'h0000_0000);
        tick <= 1'b0;
        wait_clk(3);
        chk(32'(oc_pin), 32'h0000_0001);
        $display("test compare done");
        conclude();
    end
endmodule : testbench
